/* iasm_core.sv */
// slave address match, status flags and register file of the i2c slave port
//
// Summary of operation
// - In i2c modes a read-only status bit tells whether the last byte was data or address.
// - In 10-bit addressing an address flag is set when software must load the next address part.
// - The address flag matters only in 10-bit mode and clear means no reload is needed.
// - Each set mask bit 7..1 makes that received address bit compare with the own address bit.
// - A cleared mask bit makes that received address bit ignored for matching.
// - In 10-bit slave mode (code 0111) mask bit 0 governs comparison of address bit 0.
// - Outside 10-bit slave mode mask bit 0 has no effect at all.
// - The mask register resets to all ones.
// - The eight-bit own address register is read/write, resets to zero, holds the compare value.
// - Mode code 0110 selects 7-bit slave and 0111 selects 10-bit slave addressing.
// - With mode code 1001, accesses at the own address location reach the mask register.
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module iasm_core (
	input logic clk_sys,
	input logic reset,
	input iasm_pkg::iasm_bus_req_t busReq,
	output logic [7:0] busRdata,
	input logic sclIn,
	input logic sdaIn,
	output logic sdaOut,
	output logic sdaOeN,
	output logic irq
);
	import iasm_pkg::*;

	logic [7:0] ownAddr_reg;
	logic [7:0] mask_reg;
	logic [7:0] control_reg;
	logic sampleSlew_reg;
	logic cke_reg;
	logic dataAddr_reg;
	logic addrUpdate_reg;
	logic [7:0] rxData_reg;
	logic [INT_W-1:0] intStatus_reg;
	logic [INT_W-1:0] intEnable_reg;
	logic [7:0] rdata_reg;
	logic [1:0] sclSync_reg;
	logic [1:0] sdaSync_reg;
	logic sclLast_reg;
	logic sdaLast_reg;
	iasm_state_t state_reg;
	logic [2:0] bitCnt_reg;
	logic [6:0] shift_reg;
	logic [1:0] byteIdx_reg;
	logic addressed_reg;
	logic ackReq_reg;
	logic sdaOeN_reg;
	logic addrHit_reg;

	logic [3:0] portMode;
	logic i2cOn;
	logic tenBit;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;
	logic byteDone;
	logic [7:0] byteNow;
	logic isAddr;
	logic [7:0] effMask;
	logic addrMatch;
	logic wrOwnLoc;
	logic wrMaskLoc;
	logic uaSet;
	logic [INT_W-1:0] intEvents;

	// mode decode
	assign portMode = control_reg[CTRL_MODE_LSB +: CTRL_MODE_W];
	assign tenBit = (portMode == MODE_I2C_10BIT);
	assign i2cOn = control_reg[CTRL_EN_BIT] &&
		((portMode == MODE_I2C_7BIT) || tenBit);

	// pin synchronisers, second stage is the only reader of the first
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sclSync_reg <= 2'h3;
			sdaSync_reg <= 2'h3;
			sclLast_reg <= 1'b1;
			sdaLast_reg <= 1'b1;
		end else begin
			sclSync_reg <= {sclSync_reg[0], sclIn};
			sdaSync_reg <= {sdaSync_reg[0], sdaIn};
			sclLast_reg <= sclSync_reg[1];
			sdaLast_reg <= sdaSync_reg[1];
		end
	end

	// bus conditions seen on synchronised pins
	assign sclRise = sclSync_reg[1] && !sclLast_reg;
	assign sclFall = !sclSync_reg[1] && sclLast_reg;
	assign startSeen = sclSync_reg[1] && sclLast_reg && sdaLast_reg && !sdaSync_reg[1];
	assign stopSeen = sclSync_reg[1] && sclLast_reg && !sdaLast_reg && sdaSync_reg[1];

	// byte completes on the eighth rising clock
	assign byteDone = i2cOn && (state_reg == ST_SHIFT) && sclRise && (bitCnt_reg == 3'h7);
	assign byteNow = {shift_reg, sdaSync_reg[1]};

	// address bytes: first after start, second too in 10-bit write
	assign isAddr = (byteIdx_reg == 2'h0) ||
		(tenBit && (byteIdx_reg == 2'h1) && !addressed_reg);

	// bit 0 joins the compare only in 10-bit mode
	assign effMask = {mask_reg[7:1], tenBit ? mask_reg[0] : 1'b0};

	// masked compare, cleared mask bits drop out entirely
	assign addrMatch = ((byteNow ^ ownAddr_reg) & effMask) == 8'h00;

	// receive sequencing and acknowledge drive
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			bitCnt_reg <= 3'h0;
			shift_reg <= 7'h00;
			byteIdx_reg <= 2'h0;
			addressed_reg <= 1'b0;
			ackReq_reg <= 1'b0;
			sdaOeN_reg <= 1'b1;
		end else if (!i2cOn || stopSeen) begin
			state_reg <= ST_IDLE;
			addressed_reg <= 1'b0;
			sdaOeN_reg <= 1'b1;
		end else if (startSeen) begin
			// repeated start keeps a finished 10-bit match alive
			state_reg <= ST_SHIFT;
			bitCnt_reg <= 3'h0;
			byteIdx_reg <= 2'h0;
			sdaOeN_reg <= 1'b1;
		end else begin
			case (state_reg)
				ST_SHIFT: begin
					if (sclRise) begin
						shift_reg <= byteNow[6:0];
						bitCnt_reg <= bitCnt_reg + 3'h1;
					end
					if (byteDone) begin
						state_reg <= ST_ACK_WAIT;
						if (byteIdx_reg != 2'h2) begin
							byteIdx_reg <= byteIdx_reg + 2'h1;
						end
						if (isAddr) begin
							ackReq_reg <= addrMatch;
							// 7-bit match, or low byte of a 10-bit pair
							if (addrMatch && (!tenBit || byteIdx_reg == 2'h1)) begin
								addressed_reg <= 1'b1;
							end
						end else begin
							ackReq_reg <= addressed_reg;
						end
					end
				end
				ST_ACK_WAIT: begin
					if (sclFall) begin
						sdaOeN_reg <= !ackReq_reg;
						state_reg <= ST_ACK;
					end
				end
				ST_ACK: begin
					if (sclFall) begin
						sdaOeN_reg <= 1'b1;
						bitCnt_reg <= 3'h0;
						// a refused byte parks the receiver until next start
						state_reg <= ackReq_reg ? ST_SHIFT : ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// one-cycle pulse on every own-address hit
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			addrHit_reg <= 1'b0;
		end else begin
			addrHit_reg <= byteDone && isAddr && addrMatch;
		end
	end

	// software access decode, mask load mode steals the address location
	assign wrOwnLoc = busReq.wr && (busReq.addr == OFS_OWN_ADDR) && (portMode != MODE_MASK_LOAD);
	assign wrMaskLoc = busReq.wr && (busReq.addr == OFS_OWN_ADDR) && (portMode == MODE_MASK_LOAD);

	// own address and mask storage
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ownAddr_reg <= OWN_ADDR_RST;
			mask_reg <= MASK_RST;
		end else begin
			if (wrOwnLoc) begin
				ownAddr_reg <= busReq.wdata;
			end
			if (wrMaskLoc) begin
				mask_reg <= busReq.wdata;
			end
		end
	end

	// control and the two writable status bits
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			control_reg <= CONTROL_RST;
			sampleSlew_reg <= STATUS_RST[STAT_SLEW_BIT];
			cke_reg <= STATUS_RST[STAT_CKE_BIT];
		end else begin
			if (busReq.wr && busReq.addr == OFS_CONTROL) begin
				control_reg <= busReq.wdata;
			end
			// left as software wrote them; i2c use wants them clear
			if (busReq.wr && busReq.addr == OFS_STATUS) begin
				sampleSlew_reg <= busReq.wdata[STAT_SLEW_BIT];
				cke_reg <= busReq.wdata[STAT_CKE_BIT];
			end
		end
	end

	// data/address indication follows every completed byte
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			dataAddr_reg <= STATUS_RST[STAT_DA_BIT];
		end else if (!i2cOn) begin
			dataAddr_reg <= 1'b0;
		end else if (byteDone) begin
			dataAddr_reg <= !isAddr;
		end
	end

	// update flag: a hit in 10-bit mode sets, an own address write clears
	assign uaSet = byteDone && isAddr && addrMatch && tenBit;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			addrUpdate_reg <= STATUS_RST[STAT_UPD_BIT];
		end else if (uaSet) begin
			addrUpdate_reg <= 1'b1;
		end else if (wrOwnLoc || !tenBit) begin
			addrUpdate_reg <= 1'b0;
		end
	end

	// received data byte holding register
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rxData_reg <= 8'h00;
		end else if (byteDone && !isAddr && addressed_reg) begin
			rxData_reg <= byteNow;
		end
	end

	// sticky interrupt status, a set beats a clear in the same cycle
	assign intEvents = {byteDone && !isAddr && addressed_reg, addrHit_reg};
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			intStatus_reg <= INT_RST;
			intEnable_reg <= INT_RST;
		end else begin
			if (busReq.wr && busReq.addr == OFS_INT_ENABLE) begin
				intEnable_reg <= busReq.wdata[INT_W-1:0];
			end
			if (busReq.wr && busReq.addr == OFS_INT_CLEAR) begin
				intStatus_reg <= (intStatus_reg & ~busReq.wdata[INT_W-1:0]) | intEvents;
			end else begin
				intStatus_reg <= intStatus_reg | intEvents;
			end
		end
	end

	// read data registered, valid the cycle after the strobe only
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rdata_reg <= 8'h00;
		end else if (busReq.rd) begin
			case (busReq.addr)
				OFS_STATUS: begin
					rdata_reg <= {sampleSlew_reg, cke_reg, dataAddr_reg, 3'h0, addrUpdate_reg, 1'b0};
				end
				OFS_CONTROL: begin
					rdata_reg <= control_reg;
				end
				OFS_OWN_ADDR: begin
					rdata_reg <= (portMode == MODE_MASK_LOAD) ? mask_reg : ownAddr_reg;
				end
				OFS_INT_STATUS: begin
					rdata_reg <= {6'h00, intStatus_reg};
				end
				OFS_INT_ENABLE: begin
					rdata_reg <= {6'h00, intEnable_reg};
				end
				OFS_RX_DATA: begin
					rdata_reg <= rxData_reg;
				end
				default: begin
					rdata_reg <= 8'h00;
				end
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	// outputs; open-drain data only ever pulls low
	assign busRdata = rdata_reg;
	assign sdaOut = 1'b0;
	assign sdaOeN = sdaOeN_reg;
	assign irq = |(intStatus_reg & intEnable_reg);

	chk_da_address: assert property (@(posedge clk_sys) disable iff (reset)
		byteDone && isAddr |=> !dataAddr_reg)
		else $error("data/address bit not cleared after address byte");

	chk_da_data: assert property (@(posedge clk_sys) disable iff (reset)
		byteDone && !isAddr |=> dataAddr_reg)
		else $error("data/address bit not set after data byte");

	chk_ua_set: assert property (@(posedge clk_sys) disable iff (reset)
		byteDone && isAddr && addrMatch && tenBit |=> addrUpdate_reg)
		else $error("update flag missing after 10-bit address hit");

	chk_ua_clear: assert property (@(posedge clk_sys) disable iff (reset)
		(wrOwnLoc || !tenBit) && !uaSet |=> !addrUpdate_reg)
		else $error("update flag not cleared");

	chk_mask_excl: assert property (@(posedge clk_sys) disable iff (reset)
		byteDone && isAddr && (((byteNow[7:1] ^ ownAddr_reg[7:1]) & mask_reg[7:1]) != 7'h00)
		|=> !addrHit_reg ##1 !addrHit_reg)
		else $error("hit declared with a masked-in bit differing");

	chk_bit0_ten: assert property (@(posedge clk_sys) disable iff (reset)
		byteDone && isAddr && tenBit && mask_reg[0] && (byteNow[0] != ownAddr_reg[0])
		|=> !addrHit_reg)
		else $error("bit 0 ignored in 10-bit mode");

	chk_bit0_seven: assert property (@(posedge clk_sys) disable iff (reset)
		byteDone && isAddr && !tenBit
		&& (((byteNow[7:1] ^ ownAddr_reg[7:1]) & mask_reg[7:1]) == 7'h00)
		|=> addrHit_reg)
		else $error("bit 0 affected 7-bit matching");

	chk_mask_load: assert property (@(posedge clk_sys) disable iff (reset)
		wrMaskLoc |=> (mask_reg == $past(busReq.wdata)) && $stable(ownAddr_reg))
		else $error("mask load mode did not redirect write");

	chk_own_write: assert property (@(posedge clk_sys) disable iff (reset)
		wrOwnLoc |=> (ownAddr_reg == $past(busReq.wdata)) && $stable(mask_reg))
		else $error("own address write lost");
endmodule

/* iasm_pkg.sv */
// shared constants and types for the slave address match and status block
package iasm_pkg;
	// register bus geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	// register offsets
	localparam logic [3:0] OFS_STATUS = 4'h0;
	localparam logic [3:0] OFS_CONTROL = 4'h1;
	localparam logic [3:0] OFS_OWN_ADDR = 4'h2;
	localparam logic [3:0] OFS_INT_STATUS = 4'h3;
	localparam logic [3:0] OFS_INT_ENABLE = 4'h4;
	localparam logic [3:0] OFS_INT_CLEAR = 4'h5;
	localparam logic [3:0] OFS_RX_DATA = 4'h6;

	// serial_port_status field positions
	localparam int STAT_SLEW_BIT = 7;
	localparam int STAT_CKE_BIT = 6;
	localparam int STAT_DA_BIT = 5;
	localparam int STAT_UPD_BIT = 1;

	// control field positions
	localparam int CTRL_EN_BIT = 5;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_MODE_W = 4;

	// port_mode_field codes
	localparam logic [3:0] MODE_I2C_7BIT = 4'h6;
	localparam logic [3:0] MODE_I2C_10BIT = 4'h7;
	localparam logic [3:0] MODE_MASK_LOAD = 4'h9;

	// interrupt bit positions
	localparam int INT_MATCH_BIT = 0;
	localparam int INT_RX_BIT = 1;
	localparam int INT_W = 2;

	// reset values
	localparam logic [7:0] MASK_RST = 8'hFF;
	localparam logic [7:0] OWN_ADDR_RST = 8'h00;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [1:0] INT_RST = 2'h0;

	// one register bus request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} iasm_bus_req_t;

	// receive sequencing states
	typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_ACK_WAIT, ST_ACK} iasm_state_t;
endpackage

/* iasm_master.sv */
// i2c bus master model that drives the clock and data lines of the slave port
`timescale 1ns/10ps
module iasm_master (
	input wire logic clk_sys,
	output logic scl,
	output logic sdaDrv,
	input wire logic sdaLine
);
	// idle bus: both lines released high
	initial begin
		scl = 1'b1;
		sdaDrv = 1'b1;
	end

	// a bus bit is eight system clocks, 32 ns; clock stands still between frames
	task automatic hold(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// data falls while the clock is high
	task automatic startCond();
		sdaDrv <= 1'b1;
		scl <= 1'b1;
		hold(4);
		sdaDrv <= 1'b0;
		hold(4);
		scl <= 1'b0;
		hold(2);
	endtask

	// data changes only mid low phase, away from both clock edges
	task automatic sendBit(input logic v);
		sdaDrv <= v;
		hold(2);
		scl <= 1'b1;
		hold(4);
		scl <= 1'b0;
		hold(2);
	endtask

	// msb first, then release data and sample the ack mid high phase
	task automatic writeByte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sendBit(b[i]);
		end
		sdaDrv <= 1'b1;
		hold(2);
		scl <= 1'b1;
		hold(2);
		ack = !sdaLine;
		hold(2);
		scl <= 1'b0;
		hold(2);
	endtask

	// data rises while the clock is high
	task automatic stopCond();
		sdaDrv <= 1'b0;
		hold(2);
		scl <= 1'b1;
		hold(4);
		sdaDrv <= 1'b1;
		hold(4);
	endtask
endmodule

/* iasm_core_bench.sv */
// self-checking bench for the slave address match and status block
`timescale 1ns/10ps
module iasm_core_bench;
	import iasm_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	iasm_bus_req_t busReq = '0;
	logic [7:0] busRdata;
	logic scl;
	logic sdaDrv;
	logic sdaOut;
	logic sdaOeN;
	logic irq;
	logic ack;
	logic [7:0] rdVal;
	wire sdaLine;
	int numErrors = 0;
	int testsRun = 0;

	// pull-up on the data line: high unless some party pulls it low
	assign sdaLine = sdaDrv & (sdaOeN ? 1'b1 : sdaOut);
	always #2 clk_sys = ~clk_sys;

	iasm_core dut_u (
		.clk_sys(clk_sys),
		.reset(reset),
		.busReq(busReq),
		.busRdata(busRdata),
		.sclIn(scl),
		.sdaIn(sdaLine),
		.sdaOut(sdaOut),
		.sdaOeN(sdaOeN),
		.irq(irq)
	);
	iasm_master master_u (
		.clk_sys(clk_sys),
		.scl(scl),
		.sdaDrv(sdaDrv),
		.sdaLine(sdaLine)
	);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		testsRun++;
		if (seen !== exp) begin
			numErrors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one-cycle strobes; the gap cycle keeps each strobe a single pulse
	task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		busReq.wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe; taken at the edge closing it
	task automatic readCheck(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		busReq.rd <= 1'b0;
		@(posedge clk_sys);
		rdVal = busRdata;
		check(rdVal, exp);
	endtask

	// mask only reachable through the mask load mode; sample/slew bits stay clear
	task automatic setMask(input logic [7:0] m, input logic [3:0] mode);
		regWrite(OFS_CONTROL, {4'h0, MODE_MASK_LOAD});
		regWrite(OFS_OWN_ADDR, m);
		regWrite(OFS_CONTROL, {4'h2, mode});
	endtask

	task automatic byteCheck(input logic [7:0] b, input logic expAck);
		master_u.writeByte(b, ack);
		check({7'h0, ack}, {7'h0, expAck});
	endtask

	task automatic addrFrame(input logic [7:0] b, input logic expAck);
		master_u.startCond();
		byteCheck(b, expAck);
	endtask

	task automatic endTest(input string name);
		$display("test %s done, checks %0d", name, testsRun);
	endtask

	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", testsRun, numErrors);
		if (numErrors == 0 && testsRun > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// main sequence: registers, 7-bit matching, interrupts, 10-bit matching
	initial begin
		repeat (16) @(posedge clk_sys);
		reset <= 1'b0;
		readCheck(OFS_OWN_ADDR, 8'h00);
		readCheck(OFS_STATUS, 8'h00);
		regWrite(OFS_CONTROL, {4'h0, MODE_MASK_LOAD});
		readCheck(OFS_OWN_ADDR, 8'hFF);
		regWrite(OFS_OWN_ADDR, 8'h5A);
		readCheck(OFS_OWN_ADDR, 8'h5A);
		regWrite(OFS_CONTROL, 8'h00);
		readCheck(OFS_OWN_ADDR, 8'h00);
		regWrite(OFS_OWN_ADDR, 8'hA0);
		readCheck(OFS_OWN_ADDR, 8'hA0);
		regWrite(OFS_STATUS, 8'hE2);
		readCheck(OFS_STATUS, 8'hC0);
		regWrite(OFS_STATUS, 8'h00);
		readCheck(4'h7, 8'h00);
		readCheck(OFS_INT_CLEAR, 8'h00);
		endTest("registers");
		setMask(8'hFF, MODE_I2C_7BIT);
		regWrite(OFS_INT_ENABLE, 8'h01);
		addrFrame(8'hA2, 1'b0);
		master_u.stopCond();
		addrFrame(8'hA1, 1'b1);
		readCheck(OFS_STATUS, 8'h00);
		master_u.stopCond();
		addrFrame(8'hA0, 1'b1);
		byteCheck(8'h3C, 1'b1);
		readCheck(OFS_STATUS, 8'h20);
		readCheck(OFS_RX_DATA, 8'h3C);
		readCheck(OFS_INT_STATUS, 8'h03);
		check({7'h0, irq}, 8'h01);
		regWrite(OFS_INT_CLEAR, 8'h03);
		readCheck(OFS_INT_STATUS, 8'h00);
		check({7'h0, irq}, 8'h00);
		master_u.stopCond();
		endTest("seven bit");
		// enabled only on data bytes, so an address hit must not raise the line
		setMask(8'hFD, MODE_I2C_7BIT);
		regWrite(OFS_INT_ENABLE, 8'h02);
		addrFrame(8'hA2, 1'b1);
		readCheck(OFS_INT_STATUS, 8'h01);
		check({7'h0, irq}, 8'h00);
		regWrite(OFS_INT_CLEAR, 8'h01);
		master_u.stopCond();
		endTest("mask and interrupt");
		setMask(8'hFF, MODE_I2C_10BIT);
		regWrite(OFS_OWN_ADDR, 8'hF1);
		addrFrame(8'hF0, 1'b0);
		master_u.stopCond();
		setMask(8'hFE, MODE_I2C_10BIT);
		addrFrame(8'hF0, 1'b1);
		readCheck(OFS_STATUS, 8'h02);
		regWrite(OFS_OWN_ADDR, 8'h55);
		readCheck(OFS_STATUS, 8'h00);
		byteCheck(8'h55, 1'b1);
		readCheck(OFS_STATUS, 8'h02);
		master_u.stopCond();
		regWrite(OFS_CONTROL, {4'h2, MODE_I2C_7BIT});
		readCheck(OFS_STATUS, 8'h00);
		endTest("ten bit");
		giveVerdict();
	end

	// generous limit, the whole sequence needs under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		$display("watchdog expired");
		numErrors++;
		giveVerdict();
	end
endmodule
